// >>> rtl/tpmc_pkg.sv
// Constants, register map and types of the touch panel measurement control
package tpmc_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int RES_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 16'h4028;
   localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 16'h4029;
   localparam logic [ADDR_W-1:0] ADDR_DATA_X = 16'h402A;
   localparam logic [ADDR_W-1:0] ADDR_DATA_Y = 16'h402B;
   localparam logic [ADDR_W-1:0] ADDR_DATA_Z = 16'h402C;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = 16'h402D;
   // Control 1 fields
   localparam int B_PANEL_ON = 15;
   localparam int B_CONV_GO = 14;
   localparam int B_SLEEP_ALLOW = 12;
   localparam int B_SEL_LO = 8;
   localparam int B_SEL_HI = 10;
   localparam int B_SETTLE_LO = 5;
   localparam int B_SETTLE_HI = 7;
   localparam int B_RATE_LO = 0;
   localparam int B_RATE_HI = 4;
   // Control 2 fields
   localparam int B_PEN_WAKE = 13;
   localparam int B_WIRE_MODE = 12;
   localparam int B_PEN_GATED = 11;
   localparam int B_ISEL = 8;
   localparam int B_RPU_LO = 0;
   localparam int B_RPU_HI = 3;
   // Result and flag fields
   localparam int B_RES_PEN = 15;
   localparam int B_FLAG_DATA = 1;
   localparam int B_FLAG_PEN = 0;
   localparam logic [2:0] SETTLE_RST = 3'h2;
   localparam logic [3:0] RPU_RST = 4'h7;
   localparam logic [4:0] RATE_MANUAL = 5'h00;
   // Axis codes, also the result array index
   localparam logic [1:0] AX_X = 2'h0;
   localparam logic [1:0] AX_Y = 2'h1;
   localparam logic [1:0] AX_Z = 2'h2;
   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam longint SETTLE_BASE_PS = 30000000;
   localparam longint SET_PERIOD_PS = 64'd62500000000;
   localparam int SETTLE_BASE_CYC = int'((SETTLE_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int SET_PERIOD_CYC = int'(SET_PERIOD_PS / CLK_PERIOD_PS);
   localparam int SETTLE_CW = 24;
   localparam int RATE_CW = 25;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_SETTLE = 2'b10
   } tpmc_state_e;
endpackage

// >>> rtl/tpmc_settle_timer.sv
// Settling delay timer, base count doubled per code step
`timescale 1ns/1ps
module tpmc_settle_timer import tpmc_pkg::*; #(
   parameter int BASE_CYC = SETTLE_BASE_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Control
   input wire logic i_start,
   input wire logic [2:0] i_code,
   output logic o_done
);
   logic [SETTLE_CW-1:0] cnt_r;
   logic run_r;
   logic [SETTLE_CW-1:0] load_w;

   assign load_w = SETTLE_CW'(BASE_CYC) << i_code;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            cnt_r <= load_w - SETTLE_CW'(1);
            run_r <= 1'b1;
         end else if (run_r) begin
            if (cnt_r == '0) begin
               run_r <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - SETTLE_CW'(1);
            end
         end
      end
   end
endmodule // tpmc_settle_timer

// >>> rtl/tpmc_core.sv
// Touch panel measurement scheduling, register file and event flags
`timescale 1ns/1ps
module tpmc_core import tpmc_pkg::*; #(
   parameter int SETTLE_CYC = SETTLE_BASE_CYC,
   parameter int SET_CYC = SET_PERIOD_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // Power state
   input wire logic i_pwr_off,
   input wire logic i_pwr_sleep,
   // Pen detect comparator pin
   input wire logic i_pen_down,
   // Shared converter
   input wire logic i_aux_busy,
   input wire logic i_conv_done,
   input wire logic [RES_W-1:0] i_conv_data,
   output logic o_conv_req,
   output logic [1:0] o_conv_axis,
   // Status
   output logic o_panel_active,
   output logic o_wire5,
   output logic o_wake_req,
   output logic o_data_flag,
   output logic o_pen_flag
);
   // Control fields
   logic panel_on_r, go_r, sleep_allow_r, wake_sel_r, pen_gated_r, wire5_r, isel_r;
   logic [2:0] sel_r;
   logic [2:0] settle_r;
   logic [4:0] rate_r;
   logic [3:0] rpu_r;
   // Sequencer state
   tpmc_state_e st_r;
   logic [2:0] remain_r;
   logic [1:0] axis_r;
   logic pen_seen_r, auto_set_r, auto_pend_r, suspend_r;
   logic [RATE_CW-1:0] acc_r;
   logic [B_RES_PEN:0] res_r [0:2];
   // Read hold-off
   logic inhibit_r;
   logic [2:0] read_r;
   // Pen synchroniser
   logic pen_m_r, pen_s_r, pen_d_r;
   // Flags
   logic data_flag_r, pen_flag_r;

   logic wr_c1, wr_c2, wr_fl, active_w, manual_w, auto_ok_w, start_w, fin_w;
   logic tmr_start_w, tmr_done_w, pen_rise_w, acc_hit_w, set_auto_w, set_pen_w;
   logic [2:0] mask_w, left_w, rd_hit_w;
   logic [DATA_W-1:0] rdata_nxt;
   logic [RATE_CW-1:0] acc_nxt;

   function automatic logic [1:0] first_axis(input logic [2:0] m);
      if (m[AX_X]) begin
         first_axis = AX_X;
      end else if (m[AX_Y]) begin
         first_axis = AX_Y;
      end else begin
         first_axis = AX_Z;
      end
   endfunction

   function automatic logic [2:0] axis_bit(input logic [1:0] a);
      axis_bit = 3'h1 << a;
   endfunction

   assign wr_c1 = i_wr && (i_addr == ADDR_CTRL1);
   assign wr_c2 = i_wr && (i_addr == ADDR_CTRL2);
   assign wr_fl = i_wr && (i_addr == ADDR_FLAGS);
   assign active_w = panel_on_r && !i_pwr_off && (!i_pwr_sleep || sleep_allow_r);
   assign mask_w = {sel_r[AX_Z] && !wire5_r, sel_r[AX_Y], sel_r[AX_X]};
   assign manual_w = go_r && (rate_r == RATE_MANUAL);
   assign auto_ok_w = auto_pend_r && !(pen_gated_r && suspend_r);
   assign start_w = (st_r == ST_IDLE) && active_w && !inhibit_r && !i_aux_busy
                    && (manual_w || auto_ok_w);
   assign left_w = remain_r & ~axis_bit(axis_r);
   assign fin_w = (start_w && (mask_w == 3'h0))
                  || ((st_r == ST_CONV) && i_conv_done && (left_w == 3'h0));
   assign tmr_start_w = (st_r == ST_CONV) && i_conv_done && (left_w != 3'h0);
   // Kind and pen history of the ending set; an empty set ends as it starts
   assign set_auto_w = start_w ? !manual_w : auto_set_r;
   assign set_pen_w = pen_s_r || (!start_w && pen_seen_r);
   assign pen_rise_w = pen_s_r && !pen_d_r;

   // Control register 1
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         panel_on_r <= 1'b0;
         sleep_allow_r <= 1'b0;
         sel_r <= 3'h0;
         settle_r <= SETTLE_RST;
         rate_r <= RATE_MANUAL;
      end else if (i_pwr_off) begin
         panel_on_r <= 1'b0;
      end else if (wr_c1) begin
         panel_on_r <= i_wdata[B_PANEL_ON];
         sleep_allow_r <= i_wdata[B_SLEEP_ALLOW];
         sel_r <= i_wdata[B_SEL_HI:B_SEL_LO];
         settle_r <= i_wdata[B_SETTLE_HI:B_SETTLE_LO];
         rate_r <= i_wdata[B_RATE_HI:B_RATE_LO];
      end
   end

   // Conversion go: a new write wins over the end-of-set clear
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         go_r <= 1'b0;
      end else if (wr_c1) begin
         go_r <= i_wdata[B_CONV_GO];
      end else if (fin_w && manual_w && !set_auto_w) begin
         go_r <= 1'b0;
      end
   end

   // Control register 2
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         wake_sel_r <= 1'b0;
         wire5_r <= 1'b0;
         pen_gated_r <= 1'b0;
         isel_r <= 1'b0;
         rpu_r <= RPU_RST;
      end else if (wr_c2) begin
         wake_sel_r <= i_wdata[B_PEN_WAKE];
         wire5_r <= i_wdata[B_WIRE_MODE];
         pen_gated_r <= i_wdata[B_PEN_GATED];
         isel_r <= i_wdata[B_ISEL];
         rpu_r <= i_wdata[B_RPU_HI:B_RPU_LO];
      end
   end

   // Pen detect synchroniser and edge
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         pen_m_r <= 1'b0;
         pen_s_r <= 1'b0;
         pen_d_r <= 1'b0;
      end else begin
         pen_m_r <= i_pen_down;
         pen_s_r <= pen_m_r;
         pen_d_r <= pen_s_r;
      end
   end

   // Rate accumulator: adds N per cycle, a set falls due per SET_CYC wrap
   assign acc_nxt = acc_r + RATE_CW'(rate_r);
   assign acc_hit_w = acc_nxt >= RATE_CW'(SET_CYC);
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         acc_r <= '0;
         auto_pend_r <= 1'b0;
      end else if (!(go_r && active_w) || (rate_r == RATE_MANUAL)) begin
         acc_r <= '0;
         auto_pend_r <= 1'b0;
      end else begin
         acc_r <= acc_hit_w ? acc_nxt - RATE_CW'(SET_CYC) : acc_nxt;
         if (acc_hit_w) begin
            auto_pend_r <= 1'b1;
         end else if (start_w && !manual_w) begin
            auto_pend_r <= 1'b0;
         end
      end
   end

   // Pen-gated suspension
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         suspend_r <= 1'b0;
      end else if (pen_s_r) begin
         suspend_r <= 1'b0;
      end else if (fin_w && set_auto_w && pen_gated_r && !set_pen_w) begin
         suspend_r <= 1'b1;
      end
   end

   // Measurement sequencer
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         st_r <= ST_IDLE;
         remain_r <= 3'h0;
         axis_r <= AX_X;
         pen_seen_r <= 1'b0;
         auto_set_r <= 1'b0;
         o_conv_req <= 1'b0;
      end else begin
         o_conv_req <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (start_w) begin
                  pen_seen_r <= pen_s_r;
                  auto_set_r <= !manual_w;
                  remain_r <= mask_w;
                  axis_r <= first_axis(mask_w);
                  if (mask_w != 3'h0) begin
                     st_r <= ST_CONV;
                     o_conv_req <= 1'b1;
                  end
               end
            end
            ST_CONV: begin
               if (i_conv_done) begin
                  remain_r <= left_w;
                  pen_seen_r <= pen_seen_r || pen_s_r;
                  st_r <= (left_w == 3'h0) ? ST_IDLE : ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (tmr_done_w) begin
                  axis_r <= first_axis(remain_r);
                  st_r <= ST_CONV;
                  o_conv_req <= 1'b1;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end
   assign o_conv_axis = axis_r;

   tpmc_settle_timer #(
      .BASE_CYC(SETTLE_CYC)
   ) u_settle (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_start(tmr_start_w),
      .i_code(settle_r),
      .o_done(tmr_done_w)
   );

   // Result store, pen status captured with each axis
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         for (int i = 0; i < 3; i++) begin
            res_r[i] <= '0;
         end
      end else if ((st_r == ST_CONV) && i_conv_done) begin
         res_r[axis_r] <= {pen_s_r, 3'h0, i_conv_data};
      end
   end

   // Read hold-off
   assign rd_hit_w = {i_rd && (i_addr == ADDR_DATA_Z), i_rd && (i_addr == ADDR_DATA_Y),
                      i_rd && (i_addr == ADDR_DATA_X)};
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         inhibit_r <= 1'b0;
         read_r <= 3'h0;
      end else if (rd_hit_w != 3'h0) begin
         inhibit_r <= ((read_r | rd_hit_w) & mask_w) != mask_w;
         read_r <= ((read_r | rd_hit_w) & mask_w) != mask_w ? (read_r | rd_hit_w) : 3'h0;
      end else if (i_rd || i_wr) begin
         inhibit_r <= 1'b0;
         read_r <= 3'h0;
      end
   end

   // Event flags, write one to clear, a new event wins
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         data_flag_r <= 1'b0;
         pen_flag_r <= 1'b0;
      end else begin
         data_flag_r <= fin_w || (data_flag_r && !(wr_fl && i_wdata[B_FLAG_DATA]));
         pen_flag_r <= pen_rise_w || (pen_flag_r && !(wr_fl && i_wdata[B_FLAG_PEN]));
      end
   end
   assign o_data_flag = data_flag_r;
   assign o_pen_flag = pen_flag_r;

   // Status outputs
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_panel_active <= 1'b0;
         o_wake_req <= 1'b0;
      end else begin
         o_panel_active <= active_w;
         o_wake_req <= pen_rise_w && wake_sel_r && panel_on_r && !i_pwr_off;
      end
   end
   assign o_wire5 = wire5_r;

   // Read data, valid the cycle after the strobe
   always_comb begin
      rdata_nxt = '0;
      case (i_addr)
         ADDR_CTRL1: begin
            rdata_nxt[B_PANEL_ON] = panel_on_r;
            rdata_nxt[B_CONV_GO] = go_r;
            rdata_nxt[B_SLEEP_ALLOW] = sleep_allow_r;
            rdata_nxt[B_SEL_HI:B_SEL_LO] = sel_r;
            rdata_nxt[B_SETTLE_HI:B_SETTLE_LO] = settle_r;
            rdata_nxt[B_RATE_HI:B_RATE_LO] = rate_r;
         end
         ADDR_CTRL2: begin
            rdata_nxt[B_PEN_WAKE] = wake_sel_r;
            rdata_nxt[B_WIRE_MODE] = wire5_r;
            rdata_nxt[B_PEN_GATED] = pen_gated_r;
            rdata_nxt[B_ISEL] = isel_r;
            rdata_nxt[B_RPU_HI:B_RPU_LO] = rpu_r;
         end
         ADDR_DATA_X: rdata_nxt = res_r[AX_X];
         ADDR_DATA_Y: rdata_nxt = res_r[AX_Y];
         ADDR_DATA_Z: rdata_nxt = res_r[AX_Z];
         ADDR_FLAGS: begin
            rdata_nxt[B_FLAG_DATA] = data_flag_r;
            rdata_nxt[B_FLAG_PEN] = pen_flag_r;
         end
         default: rdata_nxt = '0;
      endcase
   end
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= i_rd ? rdata_nxt : '0;
      end
   end

   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   sequence conv_ends_more;
      (st_r == ST_CONV) && i_conv_done && (left_w != 3'h0);
   endsequence
   sequence quiet_settle;
      (!o_conv_req && (st_r == ST_SETTLE)) [*8];
   endsequence

   off_clears_on_a: assert property (i_pwr_off |=> !panel_on_r && !o_panel_active)
      else $error("panel enable survived OFF state");
   sleep_gate_a: assert property (i_pwr_sleep && !sleep_allow_r |=> !o_panel_active)
      else $error("panel active in sleep without allow");
   wake_gate_a: assert property (!panel_on_r |=> !o_wake_req)
      else $error("wake raised with panel disabled");
   wake_any_sleep_a: assert property (pen_rise_w && wake_sel_r && panel_on_r && !i_pwr_off
      |=> o_wake_req)
      else $error("pen wake missed");
   manual_clear_a: assert property (fin_w && manual_w && !set_auto_w && !wr_c1 |=> !go_r)
      else $error("manual go not cleared");
   aux_hold_a: assert property ((st_r == ST_IDLE) && i_aux_busy |=> !o_conv_req)
      else $error("touch set started over busy converter");
   gated_stop_a: assert property (suspend_r && pen_gated_r && !manual_w && !pen_s_r
      |-> !start_w)
      else $error("auto set while suspended");
   pressure_4w_a: assert property (o_conv_req |-> !(wire5_r && o_conv_axis == AX_Z))
      else $error("pressure measured in 5-wire");
   axis_order_a: assert property (o_conv_req && o_conv_axis == AX_X
      |-> sel_r[AX_X] && $past(st_r) == ST_IDLE)
      else $error("X axis not first");
   settle_gap_a: assert property (conv_ends_more |=> quiet_settle)
      else $error("settle delay skipped");
   inhibit_hold_a: assert property (inhibit_r && (st_r == ST_IDLE) |=> st_r == ST_IDLE)
      else $error("set started during result read");
   data_flag_a: assert property (fin_w |=> o_data_flag)
      else $error("data ready flag not set");
endmodule // tpmc_core

// >>> test/tpmc_conv_model.sv
// Behavioural model of the shared converter seen by the touch control
`timescale 1ns/1ps
module tpmc_conv_model import tpmc_pkg::*; (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Request side
   input wire logic i_req,
   input wire logic [1:0] i_axis,
   input wire logic [3:0] i_lat,
   // Answer side
   output logic o_done,
   output logic [RES_W-1:0] o_data
);
   logic busy_r;
   logic [3:0] cnt_r;
   logic [1:0] ax_r;
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         ax_r <= 2'h0;
         o_done <= 1'b0;
         o_data <= 12'h000;
      end else begin
         o_done <= 1'b0;
         // Data toggles outside the done cycle so a stale sample shows
         o_data <= ~o_data;
         if (i_req) begin
            busy_r <= 1'b1;
            cnt_r <= i_lat;
            ax_r <= i_axis;
         end else if (busy_r) begin
            if (cnt_r == 4'h0) begin
               busy_r <= 1'b0;
               o_done <= 1'b1;
               o_data <= 12'hA50 + {10'h000, ax_r};
            end else begin
               cnt_r <= cnt_r - 4'h1;
            end
         end
      end
   end
endmodule // tpmc_conv_model

// >>> test/touch_panel_measurement_control_bench.sv
// Self-checking bench of the touch panel measurement control
`timescale 1ns/1ps
module touch_panel_measurement_control_bench import tpmc_pkg::*;;
   logic i_mclk, i_rst_b, i_wr, i_rd, i_pwr_off, i_pwr_sleep, i_pen_down, i_aux_busy;
   logic i_conv_done, o_conv_req, o_panel_active, o_wire5, o_wake_req, o_data_flag, o_pen_flag;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, o_rdata, v;
   logic [RES_W-1:0] i_conv_data;
   logic [1:0] o_conv_axis;
   logic [3:0] lat;
   logic [1:0] ax_q[$];
   int gap_q[$];
   int cyc, done_cyc, n_wake, n_fail, n_compared;

   tpmc_core #(.SETTLE_CYC(4), .SET_CYC(200)) i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_pwr_off(i_pwr_off), .i_pwr_sleep(i_pwr_sleep), .i_pen_down(i_pen_down),
      .i_aux_busy(i_aux_busy), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
      .o_conv_req(o_conv_req), .o_conv_axis(o_conv_axis), .o_panel_active(o_panel_active),
      .o_wire5(o_wire5), .o_wake_req(o_wake_req), .o_data_flag(o_data_flag),
      .o_pen_flag(o_pen_flag));
   tpmc_conv_model i_conv (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(o_conv_req),
      .i_axis(o_conv_axis), .i_lat(lat), .o_done(i_conv_done), .o_data(i_conv_data));

   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end

   // Request log with gap since the previous converter answer
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (o_conv_req === 1'b1) begin
         ax_q.push_back(o_conv_axis);
         gap_q.push_back(cyc - done_cyc);
      end
      if (i_conv_done === 1'b1) done_cyc <= cyc;
      if (o_wake_req === 1'b1) n_wake <= n_wake + 1;
   end

   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task conclude;
      $display("Compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask

   task rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   task wait_cyc(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask

   task wait_set;
      int i;
      i = 0;
      while (o_data_flag !== 1'b1 && i < 600) begin
         wait_cyc(1);
         i++;
      end
      chk("data_flag", {15'h0, o_data_flag}, 16'h0001);
      wr(ADDR_FLAGS, 16'h0003);
   endtask

   task t_reset;
      rd(ADDR_CTRL1, v);
      chk("ctrl1_reset", v, 16'h0040);
      rd(ADDR_CTRL2, v);
      chk("ctrl2_reset", v, 16'h0007);
      rd(16'h4030, v);
      chk("unmapped", v, 16'h0000);
   endtask

   task t_manual;
      wr(ADDR_CTRL2, 16'h0807);
      ax_q.delete();
      gap_q.delete();
      wr(ADDR_CTRL1, 16'hC720);
      wait_set();
      chk("n_axes", 16'(ax_q.size()), 16'h0003);
      foreach (ax_q[i]) chk("axis_order", {14'h0, ax_q[i]}, 16'(i));
      for (int i = 1; i < gap_q.size(); i++)
         chk("settle", {15'h0, gap_q[i] >= 8 && gap_q[i] <= 12}, 16'h0001);
      rd(ADDR_CTRL1, v);
      chk("go_cleared", v, 16'h8720);
      rd(ADDR_DATA_Z, v);
      chk("result_z", v & 16'h0FFF, 16'h0A52);
   endtask

   task t_wire5;
      lat <= 4'h9;
      wr(ADDR_CTRL2, 16'h1007);
      ax_q.delete();
      wr(ADDR_CTRL1, 16'hC500);
      wait_set();
      chk("wire5", {15'h0, o_wire5}, 16'h0001);
      chk("z_dropped", 16'(ax_q.size()), 16'h0001);
      rd(ADDR_DATA_X, v);
      chk("result_x", v & 16'h0FFF, 16'h0A50);
      lat <= 4'h3;
   endtask

   task t_aux;
      wr(ADDR_CTRL2, 16'h0007);
      i_aux_busy <= 1'b1;
      ax_q.delete();
      wr(ADDR_CTRL1, 16'hC100);
      wait_cyc(30);
      chk("aux_wait", 16'(ax_q.size()), 16'h0000);
      i_aux_busy <= 1'b0;
      wait_set();
      chk("aux_after", 16'(ax_q.size()), 16'h0001);
   endtask

   task t_auto;
      int nx;
      ax_q.delete();
      wr(ADDR_CTRL1, 16'hC102);
      wait_cyc(1000);
      wr(ADDR_CTRL1, 16'h8100);
      chk("auto_rate", {15'h0, ax_q.size() >= 9 && ax_q.size() <= 12}, 16'h0001);
      wr(ADDR_CTRL1, 16'hC322);
      wait_cyc(150);
      rd(ADDR_DATA_X, v);
      ax_q.delete();
      wait_cyc(400);
      nx = 0;
      foreach (ax_q[i]) if (ax_q[i] == AX_X) nx++;
      chk("holdoff", 16'(nx), 16'h0000);
      rd(ADDR_DATA_Y, v);
      wait_cyc(250);
      chk("holdoff_end", {15'h0, ax_q.size() >= 2}, 16'h0001);
      wr(ADDR_CTRL1, 16'h8000);
   endtask

   task t_gated;
      wr(ADDR_CTRL2, 16'h0807);
      ax_q.delete();
      wr(ADDR_CTRL1, 16'hC102);
      wait_cyc(500);
      chk("suspended", {15'h0, ax_q.size() <= 2}, 16'h0001);
      i_pen_down <= 1'b1;
      ax_q.delete();
      wait_cyc(500);
      chk("resumed", {15'h0, ax_q.size() >= 4}, 16'h0001);
      i_pen_down <= 1'b0;
      wr(ADDR_CTRL1, 16'h8000);
      wr(ADDR_FLAGS, 16'h0003);
      // Manual set with no axis selected, right after an auto set
      wr(ADDR_CTRL1, 16'hC000);
      wait_set();
      rd(ADDR_CTRL1, v);
      chk("empty_go_cleared", v, 16'h8000);
   endtask

   task t_power;
      wait_cyc(3);
      chk("active", {15'h0, o_panel_active}, 16'h0001);
      i_pwr_sleep <= 1'b1;
      wait_cyc(3);
      chk("sleep_off", {15'h0, o_panel_active}, 16'h0000);
      wr(ADDR_CTRL1, 16'h9000);
      wait_cyc(3);
      chk("sleep_on", {15'h0, o_panel_active}, 16'h0001);
      i_pwr_sleep <= 1'b0;
      i_pwr_off <= 1'b1;
      wait_cyc(3);
      chk("off_active", {15'h0, o_panel_active}, 16'h0000);
      i_pwr_off <= 1'b0;
      rd(ADDR_CTRL1, v);
      chk("off_clear", v, 16'h1000);
   endtask

   task t_wake;
      wr(ADDR_CTRL1, 16'h8000);
      wr(ADDR_CTRL2, 16'h2007);
      i_pwr_sleep <= 1'b1;
      n_wake = 0;
      i_pen_down <= 1'b1;
      wait_cyc(10);
      chk("wake_on", 16'(n_wake), 16'h0001);
      chk("pen_flag", {15'h0, o_pen_flag}, 16'h0001);
      i_pen_down <= 1'b0;
      wr(ADDR_CTRL1, 16'h0000);
      n_wake = 0;
      i_pen_down <= 1'b1;
      wait_cyc(10);
      chk("wake_off", 16'(n_wake), 16'h0000);
      i_pen_down <= 1'b0;
      i_pwr_sleep <= 1'b0;
   endtask

   initial begin
      i_rst_b = 1'b0;
      i_addr = 16'h0000;
      i_wdata = 16'h0000;
      {i_wr, i_rd, i_pwr_off, i_pwr_sleep, i_pen_down, i_aux_busy} = 6'h00;
      lat = 4'h3;
      {cyc, done_cyc, n_wake, n_fail, n_compared} = '0;
      repeat (12) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      t_reset();
      t_manual();
      t_wire5();
      t_aux();
      t_auto();
      t_gated();
      t_power();
      t_wake();
      conclude();
   end

   // Watchdog well beyond the expected run of some 3000 cycles
   initial begin
      repeat (20000) @(posedge i_mclk);
      n_fail++;
      conclude();
   end
endmodule // touch_panel_measurement_control_bench
